//--- core/dma_evt_irq_pkg.sv
package dma_evt_irq_pkg;
   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int NUM_CH = 32;
   localparam int NUM_REGION = 4;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CODE_W = 6;
   localparam int REGION_W = 2;
   typedef logic [DATA_W-1:0] word_t;
   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [CODE_W-1:0] code_t;
   typedef logic [REGION_W-1:0] region_t;

   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam addr_t OFS_EVT_ENABLE = 8'h00;
   localparam addr_t OFS_EVT_ENABLE_SET = 8'h04;
   localparam addr_t OFS_EVT_ENABLE_CLR = 8'h08;
   localparam addr_t OFS_QUEUED_STATUS = 8'h0c;
   localparam addr_t OFS_QUEUED_CLR = 8'h10;
   localparam addr_t OFS_IRQ_ENABLE = 8'h14;
   localparam addr_t OFS_IRQ_ENABLE_CLR = 8'h18;
   localparam addr_t OFS_IRQ_ENABLE_SET = 8'h1c;
   localparam addr_t OFS_PENDING = 8'h20;
   localparam addr_t OFS_PENDING_CLR = 8'h24;
   // global recheck, then one per shadow region at +4 each
   localparam addr_t OFS_RECHECK_GLOBAL = 8'h28;
   localparam addr_t OFS_RECHECK_SHADOW0 = 8'h2c;

   // ---------------------------------------------------------------
   // fields and reset values
   // ---------------------------------------------------------------
   localparam int RECHECK_BIT_POS = 0;
   localparam int RECHECK_RSVD_POS = 1;
   localparam word_t RST_WORD = 32'h0000_0000;
   localparam int IRQ_PULSE_CYC = 1;
endpackage : dma_evt_irq_pkg

//--- core/dma_evt_irq_if.sv
`timescale 1ns/1ps
interface dma_evt_irq_if;
   import dma_evt_irq_pkg::*;
   // event sources
   logic [NUM_CH-1:0] manual_trigger_set;
   logic [NUM_CH-1:0] external_event_latch;
   logic [NUM_CH-1:0] chained_event_latch;
   logic [NUM_CH-1:0] channel_event_enable;
   logic [NUM_CH-1:0] queued_event_status;
   logic [NUM_CH-1:0] sync_accept;
   logic [NUM_CH-1:0] hw_queue_release;
   // completion codes
   logic code_valid;
   code_t code_value;
   // interrupts
   logic [NUM_REGION-1:0] region_irq;
   modport device (
      input manual_trigger_set, external_event_latch, chained_event_latch,
      input sync_accept, hw_queue_release, code_valid, code_value,
      output channel_event_enable, queued_event_status, region_irq
   );
   modport controller (
      output manual_trigger_set, external_event_latch, chained_event_latch,
      output sync_accept, hw_queue_release, code_valid, code_value,
      input channel_event_enable, queued_event_status, region_irq
   );
endinterface : dma_evt_irq_if

//--- core/dma_evt_irq_regs.sv
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - set-port ones enable matching events
// - event enable ignores direct writes
// - accepted sync sets queued status
// - queued channel gets no further prioritizing
// - queued status cleared before next evaluation
// - queued-clear ones clear queued bits
// - irq enable changes only via ports
// - irq-enable set ones set bits
// - irq-enable clear ones clear bits
// - enable bit gates completion interrupt
// - partner returns configured completion code
// - completion code n sets pending n
// - pending holds until software clears
// - pending-clear ones clear pending bits
// - no new irq until all cleared
// - recheck in global and every shadow
// - recheck bit pulses if enabled pending
// - pulse goes to written region
// - software writes zero to bit one
// - external event needs enable bit
// - chained and manual ignore enable
module dma_evt_irq_regs (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // software register port
   input wire dma_evt_irq_pkg::addr_t reg_addr,
   input wire dma_evt_irq_pkg::word_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output dma_evt_irq_pkg::word_t reg_rdata,
   // link to the channel controller side
   dma_evt_irq_if.device link
);
   import dma_evt_irq_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [NUM_CH-1:0] evt_en;
      logic [NUM_CH-1:0] queued;
      logic [NUM_CH-1:0] irq_en;
      logic [NUM_CH-1:0] pending;
      logic [NUM_REGION-1:0] irq;
      word_t rdata;
   } state_s;

   state_s st_q;
   state_s st_d;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // one compare per port, so every write decode looks the same
   function automatic logic hit(input logic wr, input addr_t a, input addr_t ofs);
      return wr && (a == ofs);
   endfunction : hit

   // set wins when it lands in the same cycle as a clear
   function automatic word_t set_clr(input word_t q, input word_t sm, input word_t cm);
      return (q & ~cm) | sm;
   endfunction : set_clr

   // write-only ports and unmapped words read back as zero
   function automatic word_t read_mux(input addr_t a, input state_s s);
      word_t w;
      w = RST_WORD;
      case (a)
         OFS_EVT_ENABLE: w = s.evt_en;
         OFS_QUEUED_STATUS: w = s.queued;
         OFS_IRQ_ENABLE: w = s.irq_en;
         OFS_PENDING: w = s.pending;
         default: w = RST_WORD;
      endcase
      return w;
   endfunction : read_mux

   // ---------------------------------------------------------------
   // decode signals
   // ---------------------------------------------------------------
   logic evt_set_wr;
   logic evt_clr_wr;
   logic queued_clr_wr;
   logic irq_set_wr;
   logic irq_clr_wr;
   logic pending_clr_wr;
   logic recheck_glb_wr;
   logic [NUM_REGION-1:0] recheck_hit;
   logic [NUM_CH-1:0] code_set;
   logic armed;
   logic new_enabled;

   // ---------------------------------------------------------------
   // port write strobes
   // ---------------------------------------------------------------
   // the enable words have no direct write decode at all
   assign evt_set_wr = hit(reg_wr, reg_addr, OFS_EVT_ENABLE_SET);
   assign evt_clr_wr = hit(reg_wr, reg_addr, OFS_EVT_ENABLE_CLR);
   assign queued_clr_wr = hit(reg_wr, reg_addr, OFS_QUEUED_CLR);
   assign irq_set_wr = hit(reg_wr, reg_addr, OFS_IRQ_ENABLE_SET);
   assign irq_clr_wr = hit(reg_wr, reg_addr, OFS_IRQ_ENABLE_CLR);
   assign pending_clr_wr = hit(reg_wr, reg_addr, OFS_PENDING_CLR);
   // bit 1 is not decoded; software keeps it at zero
   assign recheck_glb_wr = hit(reg_wr, reg_addr, OFS_RECHECK_GLOBAL)
      && reg_wdata[RECHECK_BIT_POS];

   // ---------------------------------------------------------------
   // recheck decode, one instance per region
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_REGION; g++) begin : g_recheck
         // shadow copies decode without any access mask
         assign recheck_hit[g] = reg_wdata[RECHECK_BIT_POS] &&
            hit(reg_wr, reg_addr, ADDR_W'(OFS_RECHECK_SHADOW0 + 4 * g));
      end
   endgenerate

   // ---------------------------------------------------------------
   // completion code decode, one bit per code
   // ---------------------------------------------------------------
   // codes of 32 and up match no bit and are dropped
   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++) begin : g_code
         assign code_set[c] = link.code_valid && (link.code_value == CODE_W'(c));
      end
   endgenerate

   // ---------------------------------------------------------------
   // interrupt evaluation
   // ---------------------------------------------------------------
   // idle means no enabled pending bit left from before
   assign armed = ~|(st_q.pending & st_q.irq_en);
   // a repeated code on a bit already pending gives no new pulse
   assign new_enabled = |(code_set & ~st_q.pending & st_q.irq_en);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      // event enable only via set and clear ports
      if (evt_set_wr) begin
         st_d.evt_en = st_q.evt_en | reg_wdata;
      end
      if (evt_clr_wr) begin
         st_d.evt_en = st_q.evt_en & ~reg_wdata;
      end

      // queued status: set wins over either clear
      st_d.queued = set_clr(st_q.queued, link.sync_accept,
         (queued_clr_wr ? reg_wdata : RST_WORD) | link.hw_queue_release);

      if (irq_set_wr) begin
         st_d.irq_en = st_q.irq_en | reg_wdata;
      end
      if (irq_clr_wr) begin
         st_d.irq_en = st_q.irq_en & ~reg_wdata;
      end

      // pending only leaves by software clear; new code wins
      st_d.pending = set_clr(st_q.pending, code_set,
         pending_clr_wr ? reg_wdata : RST_WORD);

      // global instance acts as region 0
      // back-to-back rechecks of one region merge into a longer pulse
      st_d.irq = recheck_hit;
      if (recheck_glb_wr) begin
         st_d.irq[0] = 1'b1;
      end
      // recheck only fires with an enabled pending bit
      if (armed) begin
         st_d.irq = '0;
      end
      // new-code pulses go to region 0 only
      if (armed && new_enabled) begin
         st_d.irq[0] = 1'b1;
      end

      // read data stands one cycle, then falls back to zero
      st_d.rdata = RST_WORD;
      if (reg_rd) begin
         st_d.rdata = read_mux(reg_addr, st_q);
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign reg_rdata = st_q.rdata;
   assign link.channel_event_enable = st_q.evt_en;
   assign link.queued_event_status = st_q.queued;
   assign link.region_irq = st_q.irq;
endmodule : dma_evt_irq_regs

//--- core/dma_evt_prioritizer.sv
`timescale 1ns/1ps
module dma_evt_prioritizer (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // user side triggers
   input wire logic [dma_evt_irq_pkg::NUM_CH-1:0] manual_req,
   input wire logic [dma_evt_irq_pkg::NUM_CH-1:0] ext_req,
   input wire logic [dma_evt_irq_pkg::NUM_CH-1:0] chain_req,
   input wire logic [dma_evt_irq_pkg::NUM_CH-1:0] done_req,
   input wire logic done_valid,
   input wire dma_evt_irq_pkg::code_t done_code,
   // user side status
   output logic grant_valid,
   output logic [4:0] grant_ch,
   output logic [dma_evt_irq_pkg::NUM_REGION-1:0] irq_out,
   // link
   dma_evt_irq_if.controller link
);
   import dma_evt_irq_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [NUM_CH-1:0] man;
      logic [NUM_CH-1:0] ext;
      logic [NUM_CH-1:0] chn;
      logic [NUM_CH-1:0] acc;
      logic [NUM_CH-1:0] rel;
      logic cv;
      code_t code;
      logic gv;
      logic [4:0] gch;
   } state_s;

   state_s st_q;
   state_s st_d;
   logic [NUM_CH-1:0] cand;

   always_comb begin
      st_d = st_q;
      // external needs enable, manual and chained do not
      // a grant still in flight counts as queued for one more cycle
      cand = (st_q.man | st_q.chn | (st_q.ext & link.channel_event_enable))
         & ~link.queued_event_status & ~st_q.acc;
      st_d.acc = '0;
      st_d.gv = 1'b0;
      // lowest channel wins, one per cycle
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (cand[i]) begin
            st_d.acc = NUM_CH'(1) << i;
            st_d.gv = 1'b1;
            st_d.gch = 5'(i);
         end
      end
      st_d.man = (st_q.man & ~st_d.acc) | manual_req;
      st_d.ext = (st_q.ext & ~st_d.acc) | ext_req;
      st_d.chn = (st_q.chn & ~st_d.acc) | chain_req;
      st_d.rel = done_req;
      st_d.cv = done_valid;
      st_d.code = done_code;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign link.manual_trigger_set = st_q.man;
   assign link.external_event_latch = st_q.ext;
   assign link.chained_event_latch = st_q.chn;
   assign link.sync_accept = st_q.acc;
   assign link.hw_queue_release = st_q.rel;
   assign link.code_valid = st_q.cv;
   assign link.code_value = st_q.code;
   assign grant_valid = st_q.gv;
   assign grant_ch = st_q.gch;
   assign irq_out = link.region_irq;
endmodule : dma_evt_prioritizer

//--- verif/dma_evt_irq_monitor.sv
`timescale 1ns/1ps
module dma_evt_irq_monitor (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // link signals
   input wire logic [dma_evt_irq_pkg::NUM_CH-1:0] manual_trigger_set,
   input wire logic [dma_evt_irq_pkg::NUM_CH-1:0] external_event_latch,
   input wire logic [dma_evt_irq_pkg::NUM_CH-1:0] chained_event_latch,
   input wire logic [dma_evt_irq_pkg::NUM_CH-1:0] channel_event_enable,
   input wire logic [dma_evt_irq_pkg::NUM_CH-1:0] queued_event_status,
   input wire logic [dma_evt_irq_pkg::NUM_CH-1:0] sync_accept,
   input wire logic [dma_evt_irq_pkg::NUM_CH-1:0] hw_queue_release,
   input wire logic [dma_evt_irq_pkg::NUM_REGION-1:0] region_irq
);
   import dma_evt_irq_pkg::*;
   // ----------------------------------------
   // eligible sources
   // ----------------------------------------
   // past value too, since grant may lag the latch by a cycle
   logic [NUM_CH-1:0] rdy;
   assign rdy = manual_trigger_set | chained_event_latch
      | (external_event_latch & channel_event_enable);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence s_ch0_ready;
      rdy[0] && !queued_event_status[0];
   endsequence
   sequence s_ch0_served;
      ##[0:2] sync_accept[0];
   endsequence
   chk_accept_queues: assert property (
      |sync_accept |=> (queued_event_status & $past(sync_accept)) == $past(sync_accept))
      else $error("accepted channel not queued");
   chk_queue_cause: assert property (
      (queued_event_status & ~$past(queued_event_status) & ~$past(sync_accept)) == '0)
      else $error("queued bit set without accept");
   chk_one_accept: assert property ($onehot0(sync_accept))
      else $error("more than one accept");
   chk_no_requeue: assert property ((sync_accept & queued_event_status) == '0)
      else $error("queued channel accepted again");
   chk_release_clears: assert property (
      |hw_queue_release |=>
      (queued_event_status & $past(hw_queue_release) & ~$past(sync_accept)) == '0)
      else $error("release left queued bit");
   chk_source_gate: assert property (
      (sync_accept & ~(rdy | $past(rdy))) == '0)
      else $error("accept without eligible source");
   chk_ch0_served: assert property (s_ch0_ready |-> s_ch0_served)
      else $error("eligible channel not served");
   chk_irq_pulse: assert property (
      region_irq != '0 |=> (region_irq & $past(region_irq)) == '0)
      else $error("irq longer than one cycle");
endmodule : dma_evt_irq_monitor

//--- verif/dma_event_and_completion_irq_regs_tb_top.sv
`timescale 1ns/1ps
module dma_event_and_completion_irq_regs_tb_top;
   import dma_evt_irq_pkg::*;
   logic sys_clk, rst_b, reg_wr, reg_rd, done_valid, grant_valid;
   addr_t reg_addr;
   word_t reg_wdata, reg_rdata, manual_req, ext_req, chain_req, done_req, e, m;
   code_t done_code;
   logic [4:0] grant_ch, gch;
   logic [NUM_REGION-1:0] irq_out;
   int failures, checks_done, gnt_n, ch;
   int irq_n[NUM_REGION];
   addr_t ro[2] = '{OFS_EVT_ENABLE, OFS_IRQ_ENABLE};
   addr_t st[2] = '{OFS_EVT_ENABLE_SET, OFS_IRQ_ENABLE_SET};
   addr_t cl[2] = '{OFS_EVT_ENABLE_CLR, OFS_IRQ_ENABLE_CLR};
   dma_evt_irq_if link();
   dma_evt_irq_regs i_dma_evt_irq_regs (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link));
   dma_evt_prioritizer i_dma_evt_prioritizer (.sys_clk(sys_clk), .rst_b(rst_b),
      .manual_req(manual_req), .ext_req(ext_req), .chain_req(chain_req), .done_req(done_req),
      .done_valid(done_valid), .done_code(done_code), .grant_valid(grant_valid),
      .grant_ch(grant_ch), .irq_out(irq_out), .link(link));
   dma_evt_irq_monitor i_dma_evt_irq_monitor (.sys_clk(sys_clk), .rst_b(rst_b),
      .manual_trigger_set(link.manual_trigger_set),
      .external_event_latch(link.external_event_latch),
      .chained_event_latch(link.chained_event_latch), .hw_queue_release(link.hw_queue_release),
      .channel_event_enable(link.channel_event_enable), .sync_accept(link.sync_accept),
      .queued_event_status(link.queued_event_status), .region_irq(link.region_irq));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   function automatic word_t upd(word_t q, word_t s, word_t c);
      return (q | s) & ~c;
   endfunction : upd
   task automatic check(input word_t seen, input word_t exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input addr_t a, input word_t d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input addr_t a, input word_t exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask : rd
   task automatic trig(input word_t mr, input word_t er, input word_t cr, input word_t dr);
      @(posedge sys_clk);
      {manual_req, ext_req, chain_req, done_req} <= {mr, er, cr, dr};
      @(posedge sys_clk);
      {manual_req, ext_req, chain_req, done_req} <= '0;
      repeat (4) @(posedge sys_clk);
   endtask : trig
   task automatic code(input code_t n);
      @(posedge sys_clk);
      done_valid <= 1'b1;
      done_code <= n;
      @(posedge sys_clk);
      done_valid <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask : code
   task automatic close_out;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      gnt_n += (grant_valid === 1'b1);
      if (grant_valid === 1'b1) gch = grant_ch;
      foreach (irq_n[r]) irq_n[r] += (irq_out[r] === 1'b1);
   end
   // run needs about 170 cycles; limit of 5000 cycles is about thirty times that
   initial begin
      #100000;
      failures++;
      close_out();
   end
   initial begin
      {reg_wr, reg_rd, done_valid, reg_addr, reg_wdata, done_code} = '0;
      {manual_req, ext_req, chain_req, done_req} = '0;
      rst_b = 1'b0;
      void'($urandom(32'h2f7b));
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      foreach (ro[k]) begin
         e = $urandom;
         m = $urandom;
         wr(ro[k], e);
         rd(ro[k], RST_WORD);
         wr(st[k], e);
         rd(ro[k], e);
         wr(st[k], m);
         wr(cl[k], e ^ m);
         rd(ro[k], upd(e, m, e ^ m));
         wr(cl[k], '1);
         rd(ro[k], RST_WORD);
      end
      rd(8'h3c, RST_WORD);
      $display("enable test done");
      wr(OFS_IRQ_ENABLE_SET, 32'h28);
      ch = $urandom_range(31, 6);
      code(6'd3);
      code(6'd5);
      code(code_t'(ch));
      code(6'h3f);
      rd(OFS_PENDING, 32'h28 | (word_t'(1) << ch));
      check(word_t'(irq_n[0]), 32'h1);
      wr(OFS_PENDING_CLR, word_t'(1) << ch);
      rd(OFS_PENDING, 32'h28);
      // bit one stays zero in every recheck write
      for (int r = 0; r < NUM_REGION; r++) wr(OFS_RECHECK_SHADOW0 + addr_t'(4 * r), 32'h1);
      wr(OFS_RECHECK_GLOBAL, 32'h1);
      wr(OFS_RECHECK_SHADOW0, 32'h0);
      repeat (2) @(posedge sys_clk);
      foreach (irq_n[r]) check(word_t'(irq_n[r]), r ? 32'h1 : 32'h3);
      wr(OFS_PENDING_CLR, '1);
      wr(OFS_RECHECK_GLOBAL, 32'h1);
      // disabled code while idle must stay silent
      code(code_t'(ch));
      check(word_t'(irq_n[0]), 32'h3);
      wr(OFS_PENDING_CLR, word_t'(1) << ch);
      code(6'd5);
      check(word_t'(irq_n[0]), 32'h4);
      $display("irq test done");
      ch = $urandom_range(31, 1);
      m = word_t'(1) << ch;
      trig(m, '0, '0, '0);
      check(word_t'(gch), word_t'(ch));
      rd(OFS_QUEUED_STATUS, m);
      trig(m, '0, '0, '0);
      check(word_t'(gnt_n), 32'h1);
      wr(OFS_QUEUED_CLR, ~m);
      rd(OFS_QUEUED_STATUS, m);
      wr(OFS_QUEUED_CLR, m);
      repeat (4) @(posedge sys_clk);
      check(word_t'(gnt_n), 32'h2);
      trig('0, '0, '0, m);
      rd(OFS_QUEUED_STATUS, RST_WORD);
      trig('0, m, '0, '0);
      check(word_t'(gnt_n), 32'h2);
      wr(OFS_EVT_ENABLE_SET, m);
      repeat (4) @(posedge sys_clk);
      check(word_t'(gnt_n), 32'h3);
      wr(OFS_EVT_ENABLE_CLR, m);
      wr(OFS_QUEUED_CLR, m);
      // channel 0 rides along and is served first
      trig('0, '0, m | 32'h1, '0);
      check(word_t'(gnt_n), 32'h5);
      check(word_t'(gch), word_t'(ch));
      rd(OFS_QUEUED_STATUS, m | 32'h1);
      $display("queue test done");
      close_out();
   end
endmodule : dma_event_and_completion_irq_regs_tb_top
